// *** include/hpd_pkg.sv ***
// shared constants and types for the hardware-mode configuration pin decoder
package hpd_pkg;

	// control interface selection, from the two mode pins
	typedef enum logic [1:0] {
		HPD_MODE_HW       = 2'b00,
		HPD_MODE_SERIAL   = 2'b01,
		HPD_MODE_PAR_DS   = 2'b10,
		HPD_MODE_PAR_RDWR = 2'b11
	} hpd_mode_type;

	// transmit pattern select codes
	typedef enum logic [1:0] {
		HPD_PAT_NORMAL   = 2'b00,
		HPD_PAT_ALL_ONES = 2'b01,
		HPD_PAT_PRBS     = 2'b10,
		HPD_PAT_TX_OFF   = 2'b11
	} hpd_pattern_type;

	// jitter attenuator select codes
	typedef enum logic [1:0] {
		HPD_JA_OFF       = 2'b00,
		HPD_JA_RX_BROAD  = 2'b01,
		HPD_JA_RX_NARROW = 2'b10,
		HPD_JA_TX_NARROW = 2'b11
	} hpd_ja_type;

	// fifo depths in bits, and the depth reported while disabled
	localparam logic [7:0] HPD_FIFO_SHALLOW = 8'h40;
	localparam logic [7:0] HPD_FIFO_DEEP    = 8'h80;
	localparam logic [7:0] HPD_FIFO_NONE    = 8'h00;

	// timing: reset pin must stay low strictly longer than the minimum
	localparam int CLK_PERIOD_NS   = 50;
	localparam int RST_MIN_LOW_NS  = 100;
	localparam int RST_QUAL_CYC    = RST_MIN_LOW_NS / CLK_PERIOD_NS + 1;
	localparam int RST_CNT_W       = 3;

	// positions of the hardware-mode functions shared with the address pins
	localparam int ADDR_W          = 6;
	localparam int ADDR_BIT_RX2_POWER_DOWN   = 4;
	localparam int ADDR_BIT_RX1_POWER_DOWN   = 2;
	localparam int ADDR_BIT_PAT_HI = 1;
	localparam int ADDR_BIT_PAT_LO = 0;

	// width of the bundle of pins passed through the synchroniser
	localparam int SYNC_W          = 18;

endpackage

// *** hdl/hpd_sync.sv ***
// two flip-flop synchroniser for a group of pin inputs
`timescale 1ns/1ps
`default_nettype none

module hpd_sync #(
	parameter int WIDTH = 1
) (
	// clock and reset
	input  wire logic             clk_sys,
	input  wire logic             rst,
	// pins in, synchronised copy out
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] meta;

	// first stage feeds only the second stage
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			meta     <= '0;
			sync_out <= '0;
		end else begin
			meta     <= async_in;
			sync_out <= meta;
		end
	end

endmodule

`default_nettype wire

// *** hdl/hpd_decode.sv ***
// hardware control mode configuration pin decoder for a dual channel line unit
`timescale 1ns/1ps
`default_nettype none

module hpd_decode (
	// clock and reset
	input  wire logic                    clk_sys,
	input  wire logic                    rst,
	// mode and shared address pins
	input  wire logic                    control_if_select_hi,
	input  wire logic                    control_if_select_lo,
	input  wire logic [5:0]              addr_pin,
	// hardware configuration pins
	input  wire logic                    ch1_tx_pattern_sel_hi,
	input  wire logic                    ch1_tx_pattern_sel_lo,
	input  wire logic                    ch1_termination_sel,
	input  wire logic                    ch2_termination_sel,
	input  wire logic                    jitter_atten_sel_hi,
	input  wire logic                    jitter_atten_sel_lo,
	input  wire logic                    ch1_monitor_gain_sel,
	input  wire logic                    ch2_monitor_gain_sel,
	input  wire logic                    driver_high_z,
	input  wire logic                    hw_reset_n,
	input  wire logic                    test_port_reset_n,
	// line standard per channel, 1 = t1/j1, 0 = e1
	input  wire logic [1:0]              line_t1_mode,
	// software register values used outside hardware mode
	input  wire logic [1:0]              sw_rx_power_down,
	input  wire hpd_pkg::hpd_pattern_type sw_ch1_tx_pattern,
	input  wire hpd_pkg::hpd_pattern_type sw_ch2_tx_pattern,
	input  wire logic [1:0]              sw_termination_sel,
	input  wire hpd_pkg::hpd_ja_type     sw_jitter_atten_sel,
	input  wire logic [1:0]              sw_monitor_gain_sel,
	// decoded control interface
	output hpd_pkg::hpd_mode_type        control_if_mode,
	output logic [5:0]                   host_addr,
	output logic                         host_addr_valid,
	// decoded per channel settings
	output logic [1:0]                   rx_power_down,
	output hpd_pkg::hpd_pattern_type     ch1_tx_pattern,
	output hpd_pkg::hpd_pattern_type     ch2_tx_pattern,
	output logic [1:0]                   tx_power_down,
	output logic [1:0]                   rx_term_external,
	output logic [1:0]                   tx_term_external,
	output logic [1:0]                   monitor_gain_26db,
	// decoded jitter attenuator settings
	output logic                         ja_enable,
	output logic                         ja_in_tx_path,
	output logic                         ja_narrow_bw,
	output logic [7:0]                   ja_fifo_depth,
	// drivers and resets
	output logic [1:0]                   driver_enable,
	output logic                         chip_reset,
	output logic                         test_logic_reset_n
);

	import hpd_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	// pin synchronisation

	logic [SYNC_W-1:0]    pins_s;
	logic [1:0]           mode_s;
	logic [ADDR_W-1:0]    addr_s;
	logic [1:0]           ch1_pat_s;
	logic [1:0]           term_s;
	logic [1:0]           ja_s;
	logic [1:0]           mont_s;
	logic                 hz_s;
	logic                 hw_reset_s;
	logic                 hw_mode;
	logic [RST_CNT_W-1:0] rst_low_cnt;
	logic                 hw_reset_active;

	hpd_sync #(
		.WIDTH    (SYNC_W)
	) u_sync (
		.clk_sys  (clk_sys),
		.rst      (rst),
		.async_in ({control_if_select_hi, control_if_select_lo, addr_pin,
			ch1_tx_pattern_sel_hi, ch1_tx_pattern_sel_lo,
			ch2_termination_sel, ch1_termination_sel,
			jitter_atten_sel_hi, jitter_atten_sel_lo,
			ch2_monitor_gain_sel, ch1_monitor_gain_sel,
			driver_high_z, ~hw_reset_n}), // inverted: flop reset value 0 reads as idle
		.sync_out (pins_s)
	);

	// unpack the synchronised bundle
	assign {mode_s, addr_s, ch1_pat_s, term_s, ja_s, mont_s, hz_s, hw_reset_s} = pins_s;
	assign hw_mode = (mode_s == HPD_MODE_HW);

	// test logic reset is asynchronous, so it bypasses the clock entirely;
	// the pull-up lives in the pad, not here
	assign test_logic_reset_n = test_port_reset_n;

	////////////////////////////////////////////////////////////////////////////
	// hardware reset qualification

	// glitches shorter than the minimum low time never reach the core;
	// relies on the master clock running while the pin is low
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			rst_low_cnt <= '0;
		end else if (!hw_reset_s) begin
			rst_low_cnt <= '0;
		end else if (rst_low_cnt != RST_CNT_W'(RST_QUAL_CYC)) begin
			rst_low_cnt <= rst_low_cnt + 1'b1;
		end
	end

	assign hw_reset_active = (rst_low_cnt == RST_CNT_W'(RST_QUAL_CYC));
	assign chip_reset      = rst | hw_reset_active;

	////////////////////////////////////////////////////////////////////////////
	// decode helpers

	// fifo depth for a jitter attenuator selection
	function automatic logic [7:0] ja_depth(input hpd_ja_type sel);
		case (sel)
			HPD_JA_RX_BROAD:  ja_depth = HPD_FIFO_SHALLOW;
			HPD_JA_RX_NARROW: ja_depth = HPD_FIFO_DEEP;
			HPD_JA_TX_NARROW: ja_depth = HPD_FIFO_DEEP;
			default:          ja_depth = HPD_FIFO_NONE;
		endcase
	endfunction

	// pattern code from two select bits
	function automatic hpd_pattern_type pat_code(input logic [1:0] sel);
		pat_code = hpd_pattern_type'(sel);
	endfunction

	hpd_pattern_type ch2_pat_pin;
	hpd_ja_type      ja_pin;
	hpd_ja_type      ja_sel;
	hpd_pattern_type next_ch1_pat;
	hpd_pattern_type next_ch2_pat;
	logic [1:0]      next_term;

	assign ch2_pat_pin = pat_code({addr_s[ADDR_BIT_PAT_HI], addr_s[ADDR_BIT_PAT_LO]});
	assign ja_pin      = hpd_ja_type'(ja_s);

	// pins govern only in hardware mode, software values otherwise
	assign next_ch1_pat = hw_mode ? pat_code(ch1_pat_s) : sw_ch1_tx_pattern;
	assign next_ch2_pat = hw_mode ? ch2_pat_pin : sw_ch2_tx_pattern;
	assign next_term    = hw_mode ? term_s : sw_termination_sel;
	assign ja_sel       = hw_mode ? ja_pin : sw_jitter_atten_sel;

	////////////////////////////////////////////////////////////////////////////
	// control interface and address bus

	// address only valid in the parallel modes; pins are shared otherwise
	always_ff @(posedge clk_sys) begin
		if (chip_reset) begin
			control_if_mode <= HPD_MODE_HW;
			host_addr       <= '0;
			host_addr_valid <= 1'b0;
		end else begin
			control_if_mode <= hpd_mode_type'(mode_s);
			host_addr_valid <= mode_s[1];
			host_addr       <= mode_s[1] ? addr_s : '0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// per channel settings

	// receiver power down, transmit pattern, termination and monitor gain
	always_ff @(posedge clk_sys) begin
		if (chip_reset) begin
			rx_power_down     <= '0;
			ch1_tx_pattern    <= HPD_PAT_NORMAL;
			ch2_tx_pattern    <= HPD_PAT_NORMAL;
			tx_power_down     <= '0;
			rx_term_external  <= '0;
			tx_term_external  <= '0;
			monitor_gain_26db <= '0;
		end else begin
			if (hw_mode) begin
				rx_power_down <= {addr_s[ADDR_BIT_RX2_POWER_DOWN], addr_s[ADDR_BIT_RX1_POWER_DOWN]};
			end else begin
				rx_power_down <= sw_rx_power_down;
			end
			ch1_tx_pattern    <= next_ch1_pat;
			ch2_tx_pattern    <= next_ch2_pat;
			tx_power_down     <= {next_ch2_pat == HPD_PAT_TX_OFF,
				next_ch1_pat == HPD_PAT_TX_OFF};
			rx_term_external  <= next_term;
			// t1/j1 keeps internal matching on the transmit side
			tx_term_external  <= next_term & ~line_t1_mode;
			monitor_gain_26db <= hw_mode ? mont_s : sw_monitor_gain_sel;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// jitter attenuator

	// one attenuator shared by both channels
	always_ff @(posedge clk_sys) begin
		if (chip_reset) begin
			ja_enable     <= 1'b0;
			ja_in_tx_path <= 1'b0;
			ja_narrow_bw  <= 1'b0;
			ja_fifo_depth <= HPD_FIFO_NONE;
		end else begin
			ja_enable     <= (ja_sel != HPD_JA_OFF);
			ja_in_tx_path <= (ja_sel == HPD_JA_TX_NARROW);
			ja_narrow_bw  <= (ja_sel == HPD_JA_RX_NARROW) || (ja_sel == HPD_JA_TX_NARROW);
			ja_fifo_depth <= ja_depth(ja_sel);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// line drivers

	// high-z gates only the drivers; every setting above ignores it
	always_ff @(posedge clk_sys) begin
		if (chip_reset) begin
			driver_enable <= '0; // drivers stay quiet through reset
		end else begin
			driver_enable <= {2{~hz_s}};
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// assertions

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);

	property p_rx1_pd;
		!chip_reset && hw_mode |=> rx_power_down[0] == $past(addr_s[ADDR_BIT_RX1_POWER_DOWN]);
	endproperty
	a_rx1_pd: assert property (p_rx1_pd) else $error("rx1 power down mismatch");

	property p_pat_off;
		!chip_reset && hw_mode && ch2_pat_pin == HPD_PAT_TX_OFF
			|=> tx_power_down[1] && ch2_tx_pattern == HPD_PAT_TX_OFF;
	endproperty
	a_pat_off: assert property (p_pat_off) else $error("ch2 tx not powered down");

	property p_term_t1;
		!chip_reset && hw_mode && term_s[0] && line_t1_mode[0]
			|=> rx_term_external[0] && !tx_term_external[0];
	endproperty
	a_term_t1: assert property (p_term_t1) else $error("t1 termination split wrong");

	property p_ja_off;
		!chip_reset && ja_sel == HPD_JA_OFF
			|=> !ja_enable && ja_fifo_depth == HPD_FIFO_NONE;
	endproperty
	a_ja_off: assert property (p_ja_off) else $error("attenuator not disabled");

	property p_ja_broad;
		!chip_reset && ja_sel == HPD_JA_RX_BROAD
			|=> ja_enable && !ja_in_tx_path && !ja_narrow_bw && ja_fifo_depth == 8'h40;
	endproperty
	a_ja_broad: assert property (p_ja_broad) else $error("broad jitter setting wrong");

	property p_ja_tx;
		!chip_reset && ja_sel == HPD_JA_TX_NARROW
			|=> ja_in_tx_path && ja_narrow_bw && ja_fifo_depth == 8'h80;
	endproperty
	a_ja_tx: assert property (p_ja_tx) else $error("transmit jitter setting wrong");

	property p_hw_reset;
		hw_reset_s [*3] |=> chip_reset;
	endproperty
	a_hw_reset: assert property (p_hw_reset) else $error("reset not taken after 3 low cycles");

	property p_no_short_reset;
		$rose(hw_reset_active) |-> $past(hw_reset_s)
			&& $past(hw_reset_s, 2) && $past(hw_reset_s, 3);
	endproperty
	a_no_short_reset: assert property (p_no_short_reset) else $error("short pulse reset chip");

	property p_drv;
		!chip_reset |=> driver_enable == {2{!$past(hz_s)}};
	endproperty
	a_drv: assert property (p_drv) else $error("driver enable wrong");

	property p_addr;
		!chip_reset && mode_s[1] |=> host_addr_valid && host_addr == $past(addr_s);
	endproperty
	a_addr: assert property (p_addr) else $error("host address not passed");

	property p_sw_mode;
		!chip_reset && !hw_mode |=> monitor_gain_26db == $past(sw_monitor_gain_sel);
	endproperty
	a_sw_mode: assert property (p_sw_mode) else $error("pin used in software mode");

	c_hw_reset: cover property (hw_reset_s [*3] ##1 !hw_reset_s);
	c_ja_tx: cover property (hw_mode && ja_sel == HPD_JA_TX_NARROW);
	c_hz: cover property ($rose(hz_s) ##3 driver_enable == 2'b00);
	c_par: cover property (mode_s == HPD_MODE_PAR_RDWR ##1 host_addr_valid);

endmodule

`default_nettype wire

// *** verif/hpd_strap_model.sv ***
// board strapping model that drives the configuration pins of the decoder
`timescale 1ns/1ps
`default_nettype none

module hpd_strap_model (
	// requested strap settings
	input  wire logic [1:0] req_mode,
	input  wire logic [5:0] req_addr,
	input  wire logic [1:0] req_ch1_pattern,
	input  wire logic [1:0] req_term,
	input  wire logic [1:0] req_ja,
	input  wire logic [1:0] req_mon,
	input  wire logic       req_high_z,
	input  wire logic       req_hw_reset_n,
	input  wire logic       req_jtag_used,
	input  wire logic       req_trst_n,
	// pins toward the device
	output logic            control_if_select_hi,
	output logic            control_if_select_lo,
	output logic [5:0]      addr_pin,
	output logic            ch1_tx_pattern_sel_hi,
	output logic            ch1_tx_pattern_sel_lo,
	output logic            ch1_termination_sel,
	output logic            ch2_termination_sel,
	output logic            jitter_atten_sel_hi,
	output logic            jitter_atten_sel_lo,
	output logic            ch1_monitor_gain_sel,
	output logic            ch2_monitor_gain_sel,
	output logic            driver_high_z,
	output logic            hw_reset_n,
	output logic            test_port_reset_n,
	// boundary-scan mode select, held high so the test reset releases cleanly
	output logic            test_mode_sel
);
	////////////////////////////////////////////////////////////////////////////////
	// straps follow the request, but a board ties unused pins to ground
	always_comb begin
		{control_if_select_hi, control_if_select_lo} = req_mode;
		{ch1_tx_pattern_sel_hi, ch1_tx_pattern_sel_lo} = req_ch1_pattern;
		driver_high_z = req_high_z;
		hw_reset_n = req_hw_reset_n;
		addr_pin = req_addr;
		{ch2_termination_sel, ch1_termination_sel} = req_term;
		{jitter_atten_sel_hi, jitter_atten_sel_lo} = req_ja;
		{ch2_monitor_gain_sel, ch1_monitor_gain_sel} = req_mon;
		if (req_mode == 2'b00) begin
			addr_pin[5] = 1'b0;
		end else begin
			// software modes: termination, jitter and monitor gain pins grounded
			{ch2_termination_sel, ch1_termination_sel} = 2'b00;
			{jitter_atten_sel_hi, jitter_atten_sel_lo} = 2'b00;
			{ch2_monitor_gain_sel, ch1_monitor_gain_sel} = 2'b00;
		end
		if (req_mode == 2'b01) begin
			addr_pin = 6'h00;
		end
		// boundary scan unused means the test reset is tied low
		test_port_reset_n = req_jtag_used ? req_trst_n : 1'b0;
		test_mode_sel = 1'b1;
	end
endmodule

`default_nettype wire

// *** verif/hpd_decode_tb_top.sv ***
// self-checking testbench for the configuration pin decoder
`timescale 1ns/1ps
`default_nettype none

module hpd_decode_tb_top;
	import hpd_pkg::*;

	logic            clk_sys = 1'b0;
	logic            rst = 1'b1;
	logic [1:0]      line_t1_mode = 2'b00;
	logic [1:0]      sw_rx_power_down = 2'b00;
	hpd_pattern_type sw_ch1_tx_pattern = HPD_PAT_NORMAL;
	hpd_pattern_type sw_ch2_tx_pattern = HPD_PAT_NORMAL;
	logic [1:0]      sw_termination_sel = 2'b00;
	hpd_ja_type      sw_jitter_atten_sel = HPD_JA_OFF;
	logic [1:0]      sw_monitor_gain_sel = 2'b00;
	logic [1:0]      s_mode = 2'b00;
	logic [5:0]      s_addr = 6'h00;
	logic [1:0]      s_p1 = 2'b00;
	logic [1:0]      s_term = 2'b00;
	logic [1:0]      s_ja = 2'b00;
	logic [1:0]      s_mon = 2'b00;
	logic            s_hiz = 1'b0;
	logic            s_hrst_n = 1'b1;
	logic            s_jtag = 1'b0;
	logic            s_trst_n = 1'b1;
	wire logic       control_if_select_hi, control_if_select_lo;
	wire logic [5:0] addr_pin;
	wire logic       ch1_tx_pattern_sel_hi, ch1_tx_pattern_sel_lo;
	wire logic       ch1_termination_sel, ch2_termination_sel;
	wire logic       jitter_atten_sel_hi, jitter_atten_sel_lo;
	wire logic       ch1_monitor_gain_sel, ch2_monitor_gain_sel;
	wire logic       driver_high_z, hw_reset_n, test_port_reset_n;
	hpd_mode_type    control_if_mode;
	hpd_pattern_type ch1_tx_pattern, ch2_tx_pattern;
	logic [5:0]      host_addr;
	logic            host_addr_valid, ja_enable, ja_in_tx_path, ja_narrow_bw;
	logic [1:0]      rx_power_down, tx_power_down, rx_term_external;
	logic [1:0]      tx_term_external, monitor_gain_26db, driver_enable;
	logic [7:0]      ja_fifo_depth;
	logic            chip_reset, test_logic_reset_n;
	int              err_total = 0;
	int              checks = 0;

	////////////////////////////////////////////////////////////////////////////////
	// master clock keeps running through every reset
	always #25 clk_sys = ~clk_sys;

	hpd_strap_model u_hpd_strap_model (
		.req_mode(s_mode), .req_addr(s_addr), .req_ch1_pattern(s_p1), .req_term(s_term),
		.req_ja(s_ja), .req_mon(s_mon), .req_high_z(s_hiz), .req_hw_reset_n(s_hrst_n),
		.req_jtag_used(s_jtag), .req_trst_n(s_trst_n), .control_if_select_hi,
		.control_if_select_lo, .addr_pin, .ch1_tx_pattern_sel_hi, .ch1_tx_pattern_sel_lo,
		.ch1_termination_sel, .ch2_termination_sel, .jitter_atten_sel_hi,
		.jitter_atten_sel_lo, .ch1_monitor_gain_sel, .ch2_monitor_gain_sel,
		.driver_high_z, .hw_reset_n, .test_port_reset_n, .test_mode_sel());

	hpd_decode u_hpd_decode (
		.clk_sys, .rst, .control_if_select_hi, .control_if_select_lo, .addr_pin,
		.ch1_tx_pattern_sel_hi, .ch1_tx_pattern_sel_lo, .ch1_termination_sel,
		.ch2_termination_sel, .jitter_atten_sel_hi, .jitter_atten_sel_lo,
		.ch1_monitor_gain_sel, .ch2_monitor_gain_sel, .driver_high_z, .hw_reset_n,
		.test_port_reset_n, .line_t1_mode, .sw_rx_power_down, .sw_ch1_tx_pattern,
		.sw_ch2_tx_pattern, .sw_termination_sel, .sw_jitter_atten_sel, .sw_monitor_gain_sel,
		.control_if_mode, .host_addr, .host_addr_valid, .rx_power_down, .ch1_tx_pattern,
		.ch2_tx_pattern, .tx_power_down, .rx_term_external, .tx_term_external,
		.monitor_gain_26db, .ja_enable, .ja_in_tx_path, .ja_narrow_bw, .ja_fifo_depth,
		.driver_enable, .chip_reset, .test_logic_reset_n);

	////////////////////////////////////////////////////////////////////////////////
	// compare one value and count it
	task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
		checks++;
		if (seen !== exp) begin
			err_total++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// pins pass two sync flops and a register, so leave margin past three edges
	task automatic settle;
		repeat (5) @(posedge clk_sys);
		#1;
	endtask

	task automatic summarize;
		$display("checks %0d errors %0d", checks, err_total);
		if (err_total == 0 && checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	// watchdog: the sequence needs well under a thousand cycles
	initial begin
		repeat (5000) @(posedge clk_sys);
		err_total++;
		summarize;
	end

	////////////////////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		repeat (12) @(posedge clk_sys);
		rst <= 1'b0;
		settle;
		// every pattern code on both channels, receiver power downs alongside
		for (int i = 0; i < 4; i++) begin
			@(posedge clk_sys);
			s_p1 <= 2'(i);
			s_addr <= {1'b1, i[0], 1'b0, i[1], 2'(3 - i)};
			settle;
			chk("ch1_pattern", 8'(ch1_tx_pattern), 8'(i));
			chk("ch2_pattern", 8'(ch2_tx_pattern), 8'(3 - i));
			chk("tx_power_down", {6'h00, tx_power_down}, {6'h00, i == 0, i == 3});
			chk("rx_power_down", {6'h00, rx_power_down}, {6'h00, i[0], i[1]});
			chk("host_addr_valid", {7'h00, host_addr_valid}, 8'h00);
		end
		// termination against line standard, and monitor gain
		for (int i = 0; i < 16; i++) begin
			@(posedge clk_sys);
			s_term <= i[1:0];
			line_t1_mode <= i[3:2];
			s_mon <= i[1:0] ^ i[3:2];
			settle;
			chk("rx_term", {6'h00, rx_term_external}, {6'h00, i[1:0]});
			chk("tx_term", {6'h00, tx_term_external}, {6'h00, i[1:0] & ~i[3:2]});
			chk("mon_gain", {6'h00, monitor_gain_26db}, {6'h00, i[1:0] ^ i[3:2]});
		end
		// every jitter code, with driver high-z toggling underneath
		for (int i = 0; i < 4; i++) begin
			@(posedge clk_sys);
			s_ja <= 2'(i);
			s_hiz <= i[0];
			settle;
			chk("ja_enable", {7'h00, ja_enable}, {7'h00, i != 0});
			chk("ja_tx_path", {7'h00, ja_in_tx_path}, {7'h00, i == 3});
			chk("ja_narrow", {7'h00, ja_narrow_bw}, {7'h00, i[1]});
			chk("ja_depth", ja_fifo_depth, i == 0 ? 8'h00 : (i == 1 ? 8'h40 : 8'h80));
			chk("drv_enable", {6'h00, driver_enable}, {6'h00, {2{~i[0]}}});
		end
		// test port reset passes straight through while boundary scan is in use
		@(posedge clk_sys);
		s_jtag <= 1'b1;
		@(posedge clk_sys);
		#1;
		chk("trst_high", {7'h00, test_logic_reset_n}, 8'h01);
		@(posedge clk_sys);
		s_trst_n <= 1'b0;
		#1;
		chk("trst_low", {7'h00, test_logic_reset_n}, 8'h00);
		// release with the mode select held high by the strap model
		@(posedge clk_sys);
		s_trst_n <= 1'b1;
		#1;
		chk("trst_release", {7'h00, test_logic_reset_n}, 8'h01);
		// a two-cycle low pulse is too short to reset
		@(posedge clk_sys);
		s_hrst_n <= 1'b0;
		repeat (2) @(posedge clk_sys);
		s_hrst_n <= 1'b1;
		for (int k = 0; k < 8; k++) begin
			@(posedge clk_sys);
			#1;
			chk("short_pulse", {7'h00, chip_reset}, 8'h00);
		end
		// a long low resets and forces outputs to their reset values
		@(posedge clk_sys);
		s_hrst_n <= 1'b0;
		settle;
		settle;
		chk("long_pulse", {7'h00, chip_reset}, 8'h01);
		chk("depth_in_reset", ja_fifo_depth, 8'h00);
		@(posedge clk_sys);
		s_hrst_n <= 1'b1;
		settle;
		settle;
		chk("reset_release", {7'h00, chip_reset}, 8'h00);
		chk("depth_after", ja_fifo_depth, 8'h80);
		// software modes take register values and ignore the pins
		for (int m = 1; m < 4; m++) begin
			@(posedge clk_sys);
			s_mode <= 2'(m);
			s_addr <= 6'h28 + 6'(m);
			sw_rx_power_down <= m[1:0];
			sw_ch1_tx_pattern <= hpd_pattern_type'(m[1:0]);
			sw_jitter_atten_sel <= hpd_ja_type'(m[1:0]);
			sw_monitor_gain_sel <= m[1:0];
			settle;
			chk("mode", 8'(control_if_mode), 8'(m));
			chk("addr_valid", {7'h00, host_addr_valid}, {7'h00, m[1]});
			chk("host_addr", {2'b00, host_addr}, m[1] ? 8'h28 + 8'(m) : 8'h00);
			chk("sw_rx_pd", {6'h00, rx_power_down}, 8'(m));
			chk("sw_pattern", 8'(ch1_tx_pattern), 8'(m));
			chk("sw_depth", ja_fifo_depth, m == 1 ? 8'h40 : 8'h80);
			chk("sw_mon", {6'h00, monitor_gain_26db}, 8'(m));
		end
		@(posedge clk_sys);
		s_mode <= 2'b00;
		sw_ch1_tx_pattern <= HPD_PAT_NORMAL; // differs from the pins, so the source shows
		settle;
		chk("mode_hw", 8'(control_if_mode), 8'h00);
		chk("hw_pattern", 8'(ch1_tx_pattern), 8'h03);
		summarize;
	end
endmodule

`default_nettype wire
